//--- verilog/wrs_pkg.sv
// Purpose: shared constants for the watchdog and reset supervisor
// Assumes: sys_clk runs at 20 MHz
// Notes: long cycle counts are defaults for top-level parameters
package wrs_pkg;
	////////////////////////////////////////////////////////////////////////////
	// clock rate
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
	////////////////////////////////////////////////////////////////////////////
	// times in their own units
	localparam int unsigned WATCHDOG_PERIOD_MS = 1600;
	localparam int unsigned RESET_PULSE_INTERVAL_MS = 200;
	localparam int unsigned SERVICE_PULSE_MIN_WIDTH_NS = 50;
	////////////////////////////////////////////////////////////////////////////
	// derived cycle counts (min width rounds up, never below one)
	localparam int unsigned WATCHDOG_PERIOD_CYC = WATCHDOG_PERIOD_MS * CLK_PER_MS;
	localparam int unsigned RESET_PULSE_INTERVAL_CYC = RESET_PULSE_INTERVAL_MS * CLK_PER_MS;
	localparam int unsigned SVC_RAW_CYC = (SERVICE_PULSE_MIN_WIDTH_NS * (CLK_HZ / 1_000_000)
		+ 999) / 1000;
	localparam int unsigned SERVICE_PULSE_MIN_CYC = (SVC_RAW_CYC < 1) ? 1 : SVC_RAW_CYC;
	////////////////////////////////////////////////////////////////////////////
	// counter widths and reset values
	localparam int unsigned WD_CNT_W = 25;
	localparam int unsigned RST_CNT_W = 22;
	localparam logic RESET_N_INIT = 1'b0;
	localparam logic PF_FLAG_INIT = 1'b0;
	localparam int unsigned SYNC_W = 4;
endpackage : wrs_pkg

//--- verilog/wrs_sync.sv
// Purpose: two-flop synchroniser for analogue comparator results
// Assumes: inputs are asynchronous levels
// Notes: the first stage feeds only the second stage
module wrs_sync #(
	parameter int unsigned W = wrs_pkg::SYNC_W
) (
	input wire logic sys_clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic [W-1:0] async_in, // raw levels
	output logic [W-1:0] sync_out // synchronised levels
);
	import wrs_pkg::*;
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} wrs_sync_st_t;
	wrs_sync_st_t st_q;
	wrs_sync_st_t st_d;
	////////////////////////////////////////////////////////////////////////////
	// shift each level through two stages
	always_comb begin
		st_d = st_q;
		st_d.s1 = async_in;
		st_d.s2 = st_q.s1;
	end
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign sync_out = st_q.s2;
endmodule // wrs_sync

//--- verilog/wrs_top.sv
// Purpose: reset pulse generator, watchdog timer and power-fail flag
// Assumes: comparator and float-detect results arrive as raw levels
// Notes: all timing comes from sys_clk, standing in for the internal oscillator
//
// Behaviour
// - steady service input for the watchdog period expires and starts a reset
// - floating service input disables the watchdog; the timer does not count
// - watchdog timer clears on reset, on floating input, and on every edge
// - each watchdog expiry holds the active-low reset for one pulse interval
// - supply low holds reset, then one more pulse interval after it clears
// - active-high reset is always the exact inverse of active-low reset
// - outside backup mode, power-fail flag low while sense is below reference, high otherwise
// - supply low during a running pulse restarts the full interval
// - service pulses of minimum width count as edges; processor keeps that width
// - backup mode disables the power-fail path and forces the flag low
module wrs_top
#(
	parameter int unsigned WD_CYCLES = wrs_pkg::WATCHDOG_PERIOD_CYC,
	parameter int unsigned RST_CYCLES = wrs_pkg::RESET_PULSE_INTERVAL_CYC,
	parameter int unsigned WD_W = wrs_pkg::WD_CNT_W,
	parameter int unsigned RST_W = wrs_pkg::RST_CNT_W
) (
	input wire logic sys_clk, // oscillator clock
	input wire logic nrst, // async reset, active low
	input wire logic watchdog_service_input, // service level from processor
	input wire logic wdi_floating, // float detector, high when undriven
	input wire logic supply_low, // supply below reset threshold
	input wire logic pf_sense_below, // comparator: sense below reference
	input wire logic backup_mode_active, // battery connected to backed supply
	output logic reset_n_out, // active-low processor reset
	output logic reset_out, // active-high processor reset
	output logic power_fail_flag_output // low on power fail
);
	import wrs_pkg::*;
	////////////////////////////////////////////////////////////////////////////
	// state
	// one packed state; every output comes straight from one of its fields
	typedef struct packed {
		logic rst_n;
		logic rst_hi;
		logic [RST_W-1:0] rst_cnt;
		logic [WD_W-1:0] wd_cnt;
		logic wdi_prev;
		logic pf_flag;
	} wrs_st_t;
	wrs_st_t st_q;
	wrs_st_t st_d;
	logic [SYNC_W-1:0] raw_v;
	logic [SYNC_W-1:0] syn_v;
	logic float_s;
	logic low_s;
	logic below_s;
	logic backup_s;
	logic svc_edge;
	logic wd_expire;
	logic rst_done;
	////////////////////////////////////////////////////////////////////////////
	// synchronise analogue results before use
	// the service pin stays out of this path: a one-cycle pulse must still be seen
	assign raw_v = {backup_mode_active, pf_sense_below, supply_low, wdi_floating};
	wrs_sync #(
		.W(SYNC_W)
	) u_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.async_in(raw_v),
		.sync_out(syn_v)
	);
	assign float_s = syn_v[0];
	assign low_s = syn_v[1];
	assign below_s = syn_v[2];
	assign backup_s = syn_v[3];
	////////////////////////////////////////////////////////////////////////////
	// event terms; a one-cycle pulse of either level is seen as an edge
	assign svc_edge = (watchdog_service_input != st_q.wdi_prev);
	assign wd_expire = st_q.rst_n && !float_s && !svc_edge
		&& (st_q.wd_cnt == WD_W'(WD_CYCLES - 1));
	assign rst_done = (st_q.rst_cnt == RST_W'(RST_CYCLES - 1));
	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		st_d = st_q;
		st_d.wdi_prev = watchdog_service_input;
		// reset pulse generator
		// supply low wins over an expiry; either one restarts the interval from zero
		if (low_s) begin
			st_d.rst_n = 1'b0;
			st_d.rst_cnt = '0;
		end else if (wd_expire) begin
			st_d.rst_n = 1'b0;
			st_d.rst_cnt = '0;
		end else if (!st_q.rst_n) begin
			if (rst_done) begin
				st_d.rst_n = 1'b1;
				st_d.rst_cnt = '0;
			end else begin
				st_d.rst_cnt = st_q.rst_cnt + RST_W'(1);
			end
		end
		st_d.rst_hi = !st_d.rst_n;
		// watchdog timer
		// held clear while reset is low, so a fresh period starts at release
		if (!st_q.rst_n || float_s || svc_edge || wd_expire) begin
			st_d.wd_cnt = '0;
		end else begin
			st_d.wd_cnt = st_q.wd_cnt + WD_W'(1);
		end
		// power-fail flag
		// backup mode shuts the comparator path, so the flag reads as a failure
		if (backup_s) begin
			st_d.pf_flag = 1'b0;
		end else begin
			st_d.pf_flag = !below_s;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// state register
	// reset loads constants only; reset is asserted and the flag low until release
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_q.rst_n <= RESET_N_INIT;
			st_q.rst_hi <= !RESET_N_INIT;
			st_q.rst_cnt <= '0;
			st_q.wd_cnt <= '0;
			st_q.wdi_prev <= 1'b0;
			st_q.pf_flag <= PF_FLAG_INIT;
		end else begin
			st_q <= st_d;
		end
	end
	assign reset_n_out = st_q.rst_n;
	assign reset_out = st_q.rst_hi;
	assign power_fail_flag_output = st_q.pf_flag;
	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// checks read the synchronised terms, two cycles behind the pins
	expire_reset_a: assert property (wd_expire && !low_s |=> !reset_n_out)
		else $error("watchdog expiry did not assert reset");
	float_hold_a: assert property (float_s |=> st_q.wd_cnt == '0)
		else $error("watchdog counted while input floating");
	wd_clear_a: assert property (!reset_n_out |=> st_q.wd_cnt == '0)
		else $error("watchdog not clear during reset");
	edge_clear_a: assert property (svc_edge |=> st_q.wd_cnt == '0)
		else $error("service edge did not clear watchdog");
	pulse_len_a: assert property ($rose(reset_n_out) |->
		$past(st_q.rst_cnt) == RST_W'(RST_CYCLES - 1) && !$past(low_s))
		else $error("reset released before full interval");
	supply_hold_a: assert property (low_s |=> !reset_n_out && st_q.rst_cnt == '0)
		else $error("reset not held while supply low");
	restart_a: assert property (!reset_n_out && st_q.rst_cnt != '0 && low_s
		|=> st_q.rst_cnt == '0)
		else $error("supply low did not restart reset interval");
	inverse_a: assert property (reset_out == !reset_n_out)
		else $error("reset outputs not inverse");
	pf_follow_a: assert property (!backup_s |=> power_fail_flag_output == !$past(below_s))
		else $error("power-fail flag does not follow sense");
	pf_backup_a: assert property (backup_s |=> !power_fail_flag_output)
		else $error("power-fail flag not forced low in backup");
	////////////////////////////////////////////////////////////////////////////
	// counter checks; they pin the cycle timing that the pulse checks rely on
	// watchdog climbs by one on each quiet cycle while reset is released
	wd_count_a: assert property (reset_n_out && !float_s && !svc_edge && !wd_expire
		|=> st_q.wd_cnt == $past(st_q.wd_cnt) + WD_W'(1))
		else $error("watchdog did not advance on a quiet cycle");
	// the watchdog never passes its terminal count
	wd_bound_a: assert property (st_q.wd_cnt <= WD_W'(WD_CYCLES - 1))
		else $error("watchdog counter beyond its period");
	// an expiry leaves the watchdog clear for the following pulse
	expire_clear_a: assert property (wd_expire |=> st_q.wd_cnt == '0)
		else $error("watchdog not cleared by its own expiry");
	// timing resumes from zero when reset is released
	resume_a: assert property ($rose(reset_n_out) |-> st_q.wd_cnt == '0)
		else $error("watchdog not clear at reset release");
	// a floating input never lets the watchdog pull reset
	float_idle_a: assert property (float_s && reset_n_out && !low_s |=> reset_n_out)
		else $error("reset asserted while service input floating");
	// the edge detector holds the service level of the previous cycle
	edge_track_a: assert property (reset_n_out |->
		st_q.wdi_prev == $past(watchdog_service_input))
		else $error("service edge detector lost a level");
	////////////////////////////////////////////////////////////////////////////
	// reset pulse checks
	// reset falls only for a supply-low or a watchdog expiry
	fall_cause_a: assert property ($fell(reset_n_out) |->
		$past(low_s) || $past(wd_expire))
		else $error("reset fell with no trigger");
	// with no trigger a released reset stays released
	hold_high_a: assert property (reset_n_out && !low_s && !wd_expire |=> reset_n_out)
		else $error("released reset dropped untriggered");
	// a running pulse advances by one each cycle until its interval is done
	rst_count_a: assert property (!reset_n_out && !low_s && !rst_done
		|=> !reset_n_out && st_q.rst_cnt == $past(st_q.rst_cnt) + RST_W'(1))
		else $error("reset interval did not advance");
	// the interval counter stays inside its range
	rst_bound_a: assert property (st_q.rst_cnt <= RST_W'(RST_CYCLES - 1))
		else $error("reset counter beyond its interval");
	// the interval counter rests at zero while reset is released
	rst_idle_a: assert property (reset_n_out |-> st_q.rst_cnt == '0)
		else $error("reset counter running while released");
	// supply low beats a coincident expiry and still starts from zero
	low_wins_a: assert property (low_s && wd_expire
		|=> !reset_n_out && st_q.rst_cnt == '0)
		else $error("expiry overrode supply low");
	// reset is still held on the cycle the supply recovers
	low_gap_a: assert property ($fell(low_s) |-> !reset_n_out)
		else $error("reset released as supply recovered");
	////////////////////////////////////////////////////////////////////////////
	// power-fail flag checks
	// the flag rises only out of backup with the sense above reference
	pf_rise_a: assert property ($rose(power_fail_flag_output) |->
		!$past(backup_s) && !$past(below_s))
		else $error("power-fail flag rose without cause");
	// the flag falls only for low sense or backup mode
	pf_fall_a: assert property ($fell(power_fail_flag_output) |->
		$past(backup_s) || $past(below_s))
		else $error("power-fail flag fell without cause");
	////////////////////////////////////////////////////////////////////////////
	// main scenarios
	expire_c: cover property (wd_expire);
	release_c: cover property ($rose(reset_n_out));
	restart_c: cover property (!reset_n_out && st_q.rst_cnt != '0 && low_s);
	backup_c: cover property (backup_s ##1 !backup_s);
	float_c: cover property (float_s && reset_n_out);
endmodule // wrs_top

//--- tb/wrs_cpu_model.sv
// Purpose: processor model that services the watchdog
// Assumes: mode 0 tied low, 1 pulsing, 2 released
// Notes: a released line shows the inverse of its last level once, then holds
module wrs_cpu_model #(
	parameter int GAP = 30
) (
	input wire logic sys_clk, // clock
	input wire logic [1:0] mode, // service style
	output logic watchdog_service_input, // service level
	output logic wdi_floating // float detect result
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	logic svc_q = 1'b0;
	logic flt_q = 1'b0;
	assign watchdog_service_input = svc_q;
	assign wdi_floating = flt_q;
	// one-cycle service pulse every GAP+1 cycles; a steady level while released
	always @(posedge sys_clk) begin
		cnt <= (cnt >= GAP) ? 0 : cnt + 1;
		flt_q <= (mode == 2'd2);
		if (mode == 2'd2) begin
			if (!flt_q) svc_q <= ~svc_q;
		end else begin
			svc_q <= (mode == 2'd1) && (cnt == 0);
		end
	end
endmodule // wrs_cpu_model

//--- tb/test_watchdog_reset_supervisor.sv
// Purpose: self-checking bench for the supervisor
// Assumes: short counts via parameters
// Notes: pulse lengths are checked to the exact cycle
module test_watchdog_reset_supervisor;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int WD = 40;
	localparam int RS = 20;
	logic sys_clk = 0, nrst = 0, svc, flt, sup = 0, pfb = 0, bak = 0, rn, ro, pff;
	logic [1:0] mode = 2'd1;
	logic prev_rn = 0, prev_svc = 0;
	logic [31:0] b;
	int exp_q[$];
	int fails = 0, checks = 0, hi = 0, lo = 0, cyc = 0, e;
	always #25 sys_clk = ~sys_clk;
	wrs_top #(.WD_CYCLES(WD), .RST_CYCLES(RS)) uut (.sys_clk(sys_clk), .nrst(nrst),
		.watchdog_service_input(svc), .wdi_floating(flt), .supply_low(sup),
		.pf_sense_below(pfb), .backup_mode_active(bak), .reset_n_out(rn),
		.reset_out(ro), .power_fail_flag_output(pff));
	wrs_cpu_model cpu (.sys_clk(sys_clk), .mode(mode), .watchdog_service_input(svc),
		.wdi_floating(flt));
	////////////////////////////////////////////////////////////////////////////
	task automatic check(string what, logic [31:0] seen, logic [31:0] expv);
		checks++;
		if (seen !== expv) begin
			fails++;
			$display("MISMATCH %s expected %0d seen %0d", what, expv, seen);
		end
	endtask
	task automatic pop_cmp(string what, int n);
		if (exp_q.size() == 0) check({what, " unexpected"}, 1, 0);
		else begin
			e = exp_q.pop_front();
			if (e >= 0) check(what, n, e);
		end
	endtask
	task automatic wait_rn(logic v);
		while (rn !== v) @(posedge sys_clk);
	endtask
	task automatic conclude();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// watch reset edges and take the oldest noted length off the queue
	always @(posedge sys_clk) if (nrst) begin
		check("reset_out", ro, !rn);
		if (rn === 1'b1) begin
			if (!prev_rn) pop_cmp("low length", lo);
			lo = 0;
			hi = (svc !== prev_svc || flt) ? 0 : hi + 1;
		end else begin
			if (prev_rn) pop_cmp("high length", hi);
			lo++;
			hi = 0;
		end
		prev_rn = rn;
		prev_svc = svc;
	end
	// cut a hang short
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		void'($urandom(86));
		exp_q.push_back(RS);
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		wait_rn(1'b1);
		$display("test power-on done");
		repeat (3 * WD) @(posedge sys_clk);
		$display("test servicing done");
		for (int i = 0; i < 2; i++) begin
			exp_q.push_back(WD);
			exp_q.push_back(RS);
			mode <= 2'd0;
			wait_rn(1'b0);
			wait_rn(1'b1);
		end
		$display("test tied input done");
		mode <= 2'd2;
		repeat (3 * WD) @(posedge sys_clk);
		mode <= 2'd1;
		$display("test floating done");
		exp_q.push_back(-1);
		exp_q.push_back(RS + 19);
		sup <= 1'b1;
		repeat (6) @(posedge sys_clk);
		sup <= 1'b0;
		repeat (8) @(posedge sys_clk);
		sup <= 1'b1;
		repeat (6) @(posedge sys_clk);
		sup <= 1'b0;
		wait_rn(1'b0);
		wait_rn(1'b1);
		$display("test supply low done");
		repeat (24) begin
			b = $urandom;
			pfb <= b[0];
			bak <= b[1] & b[2];
			repeat (4) @(posedge sys_clk);
			check("pf flag", pff, !b[0] && !(b[1] && b[2]));
		end
		$display("test power fail done");
		check("queue left", exp_q.size(), 0);
		conclude();
	end
endmodule // test_watchdog_reset_supervisor
